// File: core/mscb_csr_bank.sv
// Host-visible misc system registers: timer view, halfword order, tick counter,
// dropped-frame tally and the indirect MAC register access pair.
// Assumes host strobes and all inputs are synchronous to mclk; mac side answers
// with a four-phase req/ack handshake.
//
// Operation
// - Timer present value readable in low 16 bits, all ones after reset.
// - Run bit falling presets timer preload to all ones and halts timer.
// - 32-bit bus: upper lines are high halfword, lower are low, swap ignored.
// - 16-bit bus, swap not all ones: address bit one selects high halfword.
// - 16-bit bus, swap all ones: address bit one selects low halfword.
// - Transmit low halfword first; first received halfword lands low.
// - 32-bit free counter from zero, one step per 25 MHz tick, wraps.
// - 16-bit bus: first halfword read latches the whole free count.
// - Free counter reads zero within 160 ns of a reset event.
// - Free counter runs in every power state.
// - Dropped-frame tally adds one per discarded receive frame.
// - A 32-bit read or a first-halfword read of the tally returns it and clears it.
// - Event raised when tally steps from 7FFFFFFF to 80000000.
// - Writing busy one starts the MAC access; busy clears when done.
// - Read data stored before busy clears.
// - Direction bit set means read, clear means write.
// - Low command byte addresses the MAC register.
// - MAC data register holds write or read value, resets to zero.
`timescale 1ns/1ns
module mscb_csr_bank #(
  parameter int TIMER_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softRst,
  input wire logic bus16,
  input wire mscb_pkg::mscb_host_req_t hostReq,
  output logic [31:0] hostRdData_ff,
  output logic hostRdValid_ff,
  input wire logic timerRun,
  input wire logic timerLoadWr,
  input wire logic [TIMER_W-1:0] timerLoadIn,
  output logic [TIMER_W-1:0] timerPreloadValue_ff,
  input wire logic rxDrop,
  output logic tallyHalfway_ff,
  output mscb_pkg::mscb_mac_req_t macReq_ff,
  input wire logic macAck,
  input wire logic [31:0] macRdData,
  input wire logic [31:0] txWordIn,
  input wire logic txWordValid,
  output logic [15:0] txHalf_ff,
  output logic txHalfValid_ff,
  input wire logic [15:0] rxHalfIn,
  input wire logic rxHalfValid,
  output logic [31:0] rxWord_ff,
  output logic rxWordValid_ff
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] half_of(input logic [31:0] word, input logic hi);
    half_of = hi ? word[31:16] : word[15:0];
  endfunction : half_of

  function automatic logic [31:0] merge_half(input logic [31:0] old, input logic [31:0] wd,
                                             input logic hi, input logic narrow);
    if (!narrow)
      merge_half = wd;
    else if (hi)
      merge_half = {wd[15:0], old[15:0]};
    else
      merge_half = {old[31:16], wd[15:0]};
  endfunction : merge_half

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [31:0] swap_ff;
  logic [31:0] tally_ff;
  logic [31:0] value_ff;
  logic cmdPending_ff;
  logic cmdDirection_ff;
  logic [7:0] cmdAddr_ff;
  logic [31:0] frSnap_ff;
  logic frHeld_ff;
  logic [31:0] dropSnap_ff;
  logic dropHeld_ff;
  logic [TIMER_W-1:0] timerCount_ff;
  logic runPrev_ff;
  logic tick;
  logic [31:0] freeCount;

  wire [7:0] ofs = {hostReq.addr[7:2], 2'b00};
  wire swapAll = (swap_ff == mscb_pkg::SWAP_ALL_ONES);
  // Swap setting only matters on the narrow bus
  wire hiSel = hostReq.addr[1] ^ swapAll;
  wire rdFree = hostReq.rd && (ofs == mscb_pkg::OFS_FREE_RUNNING_TICKS);
  wire rdDrop = hostReq.rd && (ofs == mscb_pkg::OFS_DROPPED_FRAME_TALLY);
  wire wrSwap = hostReq.wr && (ofs == mscb_pkg::OFS_HALFWORD_ORDER_SELECT);
  // Command and data writes while busy are dropped rather than corrupting a live access
  wire wrCmd = hostReq.wr && (ofs == mscb_pkg::OFS_MAC_ACCESS_COMMAND) && !cmdPending_ff;
  wire wrValue = hostReq.wr && (ofs == mscb_pkg::OFS_MAC_ACCESS_VALUE) && !cmdPending_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] cmdWord = {cmdPending_ff, cmdDirection_ff, 22'h000000, cmdAddr_ff};
  wire [31:0] freeView = (bus16 && frHeld_ff) ? frSnap_ff : freeCount;
  wire [31:0] dropView = (bus16 && dropHeld_ff) ? dropSnap_ff : tally_ff;
  wire [31:0] timerWord = {{(32 - TIMER_W){1'b0}}, timerCount_ff};
  wire [31:0] rdWord =
    (ofs == mscb_pkg::OFS_TIMER_COUNT_VIEW) ? timerWord :
    (ofs == mscb_pkg::OFS_HALFWORD_ORDER_SELECT) ? swap_ff :
    (ofs == mscb_pkg::OFS_FREE_RUNNING_TICKS) ? freeView :
    (ofs == mscb_pkg::OFS_DROPPED_FRAME_TALLY) ? dropView :
    (ofs == mscb_pkg::OFS_MAC_ACCESS_COMMAND) ? cmdWord :
    (ofs == mscb_pkg::OFS_MAC_ACCESS_VALUE) ? value_ff : 32'h0000_0000;
  wire [31:0] nxt_rdData = bus16 ? {16'h0000, half_of(rdWord, hiSel)} : rdWord;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      hostRdData_ff <= 32'h0000_0000;
      hostRdValid_ff <= 1'b0;
    end
    else
    begin
      hostRdData_ff <= hostReq.rd ? nxt_rdData : hostRdData_ff;
      hostRdValid_ff <= hostReq.rd;
    end
  end

  // ----------------------------------------------------------------
  // Halfword order and snapshots
  // ----------------------------------------------------------------
  // Order select survives soft reset, so the bus stays readable across it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      swap_ff <= mscb_pkg::SWAP_RST;
    else if (wrSwap)
      swap_ff <= merge_half(swap_ff, hostReq.wdata, hiSel, bus16);
  end

  wire frFirst = rdFree && bus16 && !frHeld_ff;
  wire dropFirst = rdDrop && bus16 && !dropHeld_ff;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      frHeld_ff <= 1'b0;
      frSnap_ff <= 32'h0000_0000;
      dropHeld_ff <= 1'b0;
      dropSnap_ff <= 32'h0000_0000;
    end
    else if (softRst)
    begin
      frHeld_ff <= 1'b0;
      dropHeld_ff <= 1'b0;
    end
    else
    begin
      frHeld_ff <= (rdFree && bus16) ? !frHeld_ff : frHeld_ff;
      frSnap_ff <= frFirst ? freeCount : frSnap_ff;
      dropHeld_ff <= (rdDrop && bus16) ? !dropHeld_ff : dropHeld_ff;
      dropSnap_ff <= dropFirst ? tally_ff : dropSnap_ff;
    end
  end

  // ----------------------------------------------------------------
  // Free-running counter
  // ----------------------------------------------------------------
  mscb_tick_counter #(
    .DIV(mscb_pkg::TICK_DIV),
    .CNT_W(32)
  ) u_ticks (
    .mclk(mclk),
    .rst(rst),
    .softClr(softRst),
    .tick(tick),
    .count(freeCount)
  );

  // ----------------------------------------------------------------
  // Dropped-frame tally
  // ----------------------------------------------------------------
  // On the narrow bus the clear happens on the first half, the second half comes from the snapshot
  wire tallyClr = rdDrop && (!bus16 || !dropHeld_ff);
  // A drop in the clearing cycle is kept as the new count
  wire [31:0] nxt_tally = tallyClr ? {31'h0, rxDrop} : tally_ff + {31'h0, rxDrop};
  wire nxt_halfway = !tallyClr && rxDrop && (tally_ff == mscb_pkg::TALLY_BELOW_HALF);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tally_ff <= 32'h0000_0000;
      tallyHalfway_ff <= 1'b0;
    end
    else if (softRst)
    begin
      tally_ff <= 32'h0000_0000;
      tallyHalfway_ff <= 1'b0;
    end
    else
    begin
      tally_ff <= nxt_tally;
      tallyHalfway_ff <= nxt_halfway;
    end
  end

  // ----------------------------------------------------------------
  // General purpose timer
  // ----------------------------------------------------------------
  wire runFall = runPrev_ff && !timerRun;
  wire runRise = !runPrev_ff && timerRun;
  wire timerZero = (timerCount_ff == '0);
  wire [TIMER_W-1:0] nxt_timer =
    runRise ? timerPreloadValue_ff :
    (timerRun && tick) ? (timerZero ? timerPreloadValue_ff : timerCount_ff - TIMER_W'(1)) :
    timerCount_ff; // Halts when run is low

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      runPrev_ff <= 1'b0;
      timerPreloadValue_ff <= TIMER_W'(mscb_pkg::TIMER_RST);
      timerCount_ff <= TIMER_W'(mscb_pkg::TIMER_RST);
    end
    else
    begin
      runPrev_ff <= timerRun;
      if (runFall)
        timerPreloadValue_ff <= TIMER_W'(mscb_pkg::TIMER_RST);
      else if (timerLoadWr)
        timerPreloadValue_ff <= timerLoadIn;
      timerCount_ff <= nxt_timer;
    end
  end

  // ----------------------------------------------------------------
  // MAC indirect access
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MS_IDLE, MS_WAIT_ACK, MS_WAIT_REL} mscb_mac_state_t;
  mscb_mac_state_t state_ff;

  wire [31:0] cmdMerged = merge_half(cmdWord, hostReq.wdata, hiSel, bus16);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= MS_IDLE;
      cmdPending_ff <= 1'b0;
      cmdDirection_ff <= 1'b0;
      cmdAddr_ff <= 8'h00;
      value_ff <= mscb_pkg::VALUE_RST;
      macReq_ff <= '0;
    end
    else if (softRst)
    begin
      state_ff <= MS_IDLE;
      cmdPending_ff <= 1'b0;
      cmdDirection_ff <= 1'b0;
      cmdAddr_ff <= 8'h00;
      value_ff <= mscb_pkg::VALUE_RST;
      macReq_ff <= '0;
    end
    else
    begin
      if (wrCmd)
      begin
        cmdPending_ff <= cmdMerged[mscb_pkg::CMD_PENDING_BIT];
        cmdDirection_ff <= cmdMerged[mscb_pkg::CMD_DIRECTION_BIT];
        cmdAddr_ff <= cmdMerged[mscb_pkg::CMD_ADDR_LSB +: mscb_pkg::CMD_ADDR_W];
      end
      if (wrValue)
        value_ff <= merge_half(value_ff, hostReq.wdata, hiSel, bus16);
      unique case (state_ff)
        MS_IDLE:
        begin
          if (cmdPending_ff)
          begin
            // Request fields are held stable for the whole handshake
            macReq_ff <= '{valid: 1'b1, read: cmdDirection_ff, addr: cmdAddr_ff, wdata: value_ff};
            state_ff <= MS_WAIT_ACK;
          end
        end
        MS_WAIT_ACK:
        begin
          if (macAck)
          begin
            if (macReq_ff.read)
              value_ff <= macRdData;
            macReq_ff.valid <= 1'b0;
            state_ff <= MS_WAIT_REL;
          end
        end
        MS_WAIT_REL:
        begin
          if (!macAck)
          begin
            cmdPending_ff <= 1'b0;
            state_ff <= MS_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // FIFO halfword order
  // ----------------------------------------------------------------
  // Network order is fixed, independent of the host order select
  logic [15:0] txHigh_ff;
  logic txHighPend_ff;
  logic rxLowHeld_ff;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txHalf_ff <= 16'h0000;
      txHalfValid_ff <= 1'b0;
      txHigh_ff <= 16'h0000;
      txHighPend_ff <= 1'b0;
    end
    else
    begin
      txHalfValid_ff <= txWordValid || txHighPend_ff;
      txHighPend_ff <= txWordValid;
      if (txWordValid)
      begin
        txHalf_ff <= txWordIn[15:0];
        txHigh_ff <= txWordIn[31:16];
      end
      else if (txHighPend_ff)
        txHalf_ff <= txHigh_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxWord_ff <= 32'h0000_0000;
      rxWordValid_ff <= 1'b0;
      rxLowHeld_ff <= 1'b0;
    end
    else
    begin
      rxWordValid_ff <= rxHalfValid && rxLowHeld_ff;
      if (rxHalfValid)
      begin
        rxLowHeld_ff <= !rxLowHeld_ff;
        if (rxLowHeld_ff)
          rxWord_ff[31:16] <= rxHalfIn;
        else
          rxWord_ff[15:0] <= rxHalfIn;
      end
    end
  end

endmodule : mscb_csr_bank

// File: core/mscb_tick_counter.sv
// Divider for the 25 MHz tick enable and the free-running tick counter.
// Assumes mclk at 100 MHz; softClr is a synchronous one-cycle pulse.
`timescale 1ns/1ns
module mscb_tick_counter #(
  parameter int DIV = mscb_pkg::TICK_DIV,
  parameter int CNT_W = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softClr,
  output logic tick,
  output logic [CNT_W-1:0] count
);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [7:0] div_ff;
  wire divEnd = (div_ff == 8'(DIV - 1));
  wire [7:0] nxt_div = divEnd ? 8'h00 : div_ff + 8'h01;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_ff <= 8'h00;
    else if (softClr)
      div_ff <= 8'h00;
    else
      div_ff <= nxt_div;
  end

  assign tick = divEnd;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // No power-state input gates this counter, so it runs in every state
  logic [CNT_W-1:0] count_ff;
  wire [CNT_W-1:0] nxt_count = count_ff + CNT_W'(1);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      count_ff <= '0;
    else if (softClr)
      count_ff <= '0; // Cleared in one cycle, well inside the allowed window
    else if (divEnd)
      count_ff <= nxt_count; // Natural wrap after all ones
  end

  assign count = count_ff;

endmodule : mscb_tick_counter

// File: shared/mscb_pkg.sv
// Constants, register map and carrier types for the misc system register bank.
// Assumes a single 100 MHz clock and the documented byte offsets on the host bus.
package mscb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 40;
  localparam int TICK_DIV = TICK_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int FR_CLEAR_NS = 160;
  localparam int FR_CLEAR_CYC = (FR_CLEAR_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_COUNT_VIEW = 8'h90;
  localparam logic [7:0] OFS_HALFWORD_ORDER_SELECT = 8'h98;
  localparam logic [7:0] OFS_FREE_RUNNING_TICKS = 8'h9C;
  localparam logic [7:0] OFS_DROPPED_FRAME_TALLY = 8'hA0;
  localparam logic [7:0] OFS_MAC_ACCESS_COMMAND = 8'hA4;
  localparam logic [7:0] OFS_MAC_ACCESS_VALUE = 8'hA8;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CMD_PENDING_BIT = 31;
  localparam int CMD_DIRECTION_BIT = 30;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_ADDR_W = 8;
  localparam logic [15:0] TIMER_RST = 16'hFFFF;
  localparam logic [31:0] SWAP_RST = 32'h0000_0000;
  localparam logic [31:0] SWAP_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] VALUE_RST = 32'h0000_0000;
  localparam logic [31:0] TALLY_BELOW_HALF = 32'h7FFF_FFFF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mscb_host_req_t;

  typedef struct packed {
    logic valid;
    logic read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mscb_mac_req_t;

endpackage : mscb_pkg

// File: test/mscb_csr_bank_assertions.sv
// Port checker for the misc system register bank.
// Assumes one mclk domain and the async active-high rst.
`timescale 1ns/1ns
module mscb_csr_bank_assertions #(
  parameter int TIMER_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire mscb_pkg::mscb_host_req_t hostReq,
  input wire logic hostRdValid_ff,
  input wire logic timerRun,
  input wire logic [TIMER_W-1:0] timerPreloadValue_ff,
  input wire logic rxDrop,
  input wire logic tallyHalfway_ff,
  input wire mscb_pkg::mscb_mac_req_t macReq_ff,
  input wire logic macAck,
  input wire logic [31:0] txWordIn,
  input wire logic txWordValid,
  input wire logic [15:0] txHalf_ff,
  input wire logic txHalfValid_ff
);
  // ----------------------------------------------------------------
  // Clocking and helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire cmdStart = hostReq.wr && hostReq.addr == 8'hA4 && hostReq.wdata[31];

  sequence txLowHalf;
    txHalfValid_ff && txHalf_ff == $past(txWordIn[15:0]);
  endsequence
  sequence txHighHalf;
    txHalfValid_ff && txHalf_ff == $past(txWordIn[31:16], 2);
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  rd_answer_a: assert property (hostReq.rd |=> hostRdValid_ff)
    else $error("read not answered next cycle");
  rd_quiet_a: assert property (!hostReq.rd |=> !hostRdValid_ff)
    else $error("read valid without a read");
  mac_start_a: assert property ($rose(macReq_ff.valid) |-> $past(cmdStart, 2)
    && macReq_ff.read == $past(hostReq.wdata[30], 2) && macReq_ff.addr == $past(hostReq.wdata[7:0], 2))
    else $error("mac request without matching command");
  mac_hold_a: assert property (macReq_ff.valid && !macAck |=> macReq_ff.valid && $stable(macReq_ff))
    else $error("mac request changed before ack");
  mac_drop_a: assert property (macReq_ff.valid && macAck |=> !macReq_ff.valid)
    else $error("mac request held after ack");
  mac_quiet_a: assert property (!macReq_ff.valid && macAck |=> !macReq_ff.valid)
    else $error("new mac request before ack release");
  tx_order_a: assert property (txWordValid |=> txLowHalf ##1 txHighHalf)
    else $error("tx halfwords wrong or out of order");
  preload_a: assert property ($fell(timerRun) |=> timerPreloadValue_ff == {TIMER_W{1'b1}})
    else $error("preload not all ones after run drop");
  halfway_a: assert property (tallyHalfway_ff |-> ($past(rxDrop) || $past(rxDrop, 2)) ##1 !tallyHalfway_ff)
    else $error("halfway pulse without drop or too long");
endmodule : mscb_csr_bank_assertions

bind mscb_csr_bank mscb_csr_bank_assertions #(.TIMER_W(TIMER_W)) chk (.mclk(mclk), .rst(rst), .hostReq(hostReq),
  .hostRdValid_ff(hostRdValid_ff), .timerRun(timerRun), .timerPreloadValue_ff(timerPreloadValue_ff),
  .rxDrop(rxDrop), .tallyHalfway_ff(tallyHalfway_ff), .macReq_ff(macReq_ff), .macAck(macAck),
  .txWordIn(txWordIn), .txWordValid(txWordValid), .txHalf_ff(txHalf_ff), .txHalfValid_ff(txHalfValid_ff));

// File: test/mscb_mac_model.sv
// Behavioural MAC register space on the far side of the request handshake.
// Assumes the four-phase valid/ack protocol; lag sets the answer delay.
`timescale 1ns/1ns
module mscb_mac_model (
  input wire logic mclk,
  input wire logic rst,
  input wire mscb_pkg::mscb_mac_req_t macReq,
  input wire logic [7:0] lag,
  output logic macAck,
  output logic [31:0] macRdData
);
  logic [31:0] mem [256];
  logic [7:0] waitCnt;

  always @(posedge mclk or posedge rst)
    if (rst)
    begin
      macAck <= 1'b0;
      waitCnt <= 8'h00;
      macRdData <= 32'h0;
    end
    else if (macReq.valid && !macAck)
    begin
      if (waitCnt < lag)
        waitCnt <= waitCnt + 8'h01;
      else
      begin
        macAck <= 1'b1;
        waitCnt <= 8'h00;
        if (macReq.read)
          macRdData <= mem[macReq.addr];
        else
          mem[macReq.addr] <= macReq.wdata;
      end
    end
    else if (macAck && !macReq.valid)
    begin
      macAck <= 1'b0;
      macRdData <= ~macRdData; // Stale data must not look valid
    end
endmodule : mscb_mac_model

// File: test/tb.sv
// Self-checking bench for the misc system register bank.
// Assumes the bank and the MAC model; inputs change at the falling edge.
`timescale 1ns/1ns
module tb;
  logic mclk, rst, softRst, bus16, timerRun, timerLoadWr, rxDrop, macAck, txWordValid, rxHalfValid;
  logic hostRdValid_ff, txHalfValid_ff, rxWordValid_ff, tallyHalfway_ff;
  logic [15:0] timerLoadIn, timerPreloadValue_ff, rxHalfIn, txHalf_ff;
  logic [31:0] macRdData, txWordIn, hostRdData_ff, rxWord_ff, v, w;
  logic [7:0] lag;
  mscb_pkg::mscb_host_req_t hostReq;
  mscb_pkg::mscb_mac_req_t macReq_ff;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  mscb_csr_bank uut (.mclk(mclk), .rst(rst), .softRst(softRst), .bus16(bus16), .hostReq(hostReq),
    .hostRdData_ff(hostRdData_ff), .hostRdValid_ff(hostRdValid_ff), .timerRun(timerRun),
    .timerLoadWr(timerLoadWr), .timerLoadIn(timerLoadIn), .timerPreloadValue_ff(timerPreloadValue_ff),
    .rxDrop(rxDrop), .tallyHalfway_ff(tallyHalfway_ff), .macReq_ff(macReq_ff), .macAck(macAck),
    .macRdData(macRdData), .txWordIn(txWordIn), .txWordValid(txWordValid), .txHalf_ff(txHalf_ff),
    .txHalfValid_ff(txHalfValid_ff), .rxHalfIn(rxHalfIn), .rxHalfValid(rxHalfValid), .rxWord_ff(rxWord_ff),
    .rxWordValid_ff(rxWordValid_ff));
  mscb_mac_model mac (.mclk(mclk), .rst(rst), .macReq(macReq_ff), .lag(lag), .macAck(macAck),
    .macRdData(macRdData));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    hostReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk);
    hostReq.wr = 1'b0;
  endtask : wr

  // Read valid stands one cycle and data holds until the next read, so both are taken where the strobe drops
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge mclk);
    hostReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(negedge mclk);
    hostReq.rd = 1'b0;
    chk("read valid", {31'h0, hostRdValid_ff}, 32'h1);
    d = hostRdData_ff;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask : rdc

  // Bounded wait for the pending bit to clear
  task automatic poll();
    int k;
    k = 0;
    rd(8'hA4, v);
    while (v[31] !== 1'b0 && k < 60)
    begin
      rd(8'hA4, v);
      k++;
    end
    chk("pending", {31'h0, v[31]}, 32'h0);
  endtask : poll

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    hostReq = '0;
    rst = 1'b1;
    {softRst, bus16, timerRun, timerLoadWr, rxDrop, txWordValid, rxHalfValid} = 7'h00;
    {timerLoadIn, rxHalfIn, txWordIn, lag} = '0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    rdc(8'h90, 32'h0000FFFF);
    rdc(8'h98, 32'h00000000);
    rdc(8'hA0, 32'h00000000);
    rdc(8'hA4, 32'h00000000);
    rdc(8'hA8, 32'h00000000);
    rdc(8'h50, 32'h00000000);
    wr(8'h90, 32'h00000000);
    rdc(8'h90, 32'h0000FFFF);
    $display("test reset done");
    // Reads 40 cycles apart span exactly 10 ticks
    rd(8'h9C, v);
    repeat (38) @(negedge mclk);
    rd(8'h9C, w);
    chk("tick step", w - v, 32'h0000000A);
    softRst = 1'b1;
    @(negedge mclk);
    softRst = 1'b0;
    rd(8'h9C, v);
    chk("tick clear", {31'h0, v < 32'h00000002}, 32'h1);
    $display("test ticks done");
    timerLoadIn = 16'h0040;
    timerLoadWr = 1'b1;
    @(negedge mclk);
    timerLoadWr = 1'b0;
    timerRun = 1'b1;
    repeat (20) @(negedge mclk);
    rd(8'h90, v);
    chk("timer runs", {31'h0, v < 32'h00000040}, 32'h1);
    timerRun = 1'b0;
    @(negedge mclk);
    chk("preload", {16'h0, timerPreloadValue_ff}, 32'h0000FFFF);
    rd(8'h90, v);
    repeat (8) @(negedge mclk);
    rdc(8'h90, v);
    $display("test timer done");
    wr(8'hA8, 32'h12345678);
    bus16 = 1'b1;
    rdc(8'hA8, 32'h00005678);
    rdc(8'hAA, 32'h00001234);
    wr(8'h98, 32'h0000FFFF);
    wr(8'h9A, 32'h0000FFFF);
    rdc(8'hA8, 32'h00001234);
    rdc(8'hAA, 32'h00005678);
    // Wide bus must ignore the all-ones order select
    bus16 = 1'b0;
    rdc(8'hA8, 32'h12345678);
    bus16 = 1'b1;
    wr(8'h98, 32'h00000000);
    wr(8'h98, 32'h00000000);
    // Captures 44 cycles apart: a latched low half moves by 11 ticks
    rd(8'h9E, v);
    repeat (40) @(negedge mclk);
    rd(8'h9C, v);
    rd(8'h9C, w);
    chk("tick latch", w - v, 32'h0000000B);
    rd(8'h9E, v);
    bus16 = 1'b0;
    rdc(8'hA8, 32'h12345678);
    $display("test halfword order done");
    rxDrop = 1'b1;
    repeat (3) @(negedge mclk);
    rxDrop = 1'b0;
    rdc(8'hA0, 32'h00000003);
    rdc(8'hA0, 32'h00000000);
    // Narrow bus: first half clears the tally, second half comes from the capture
    bus16 = 1'b1;
    rxDrop = 1'b1;
    repeat (2) @(negedge mclk);
    rxDrop = 1'b0;
    rdc(8'hA0, 32'h00000002);
    rdc(8'hA2, 32'h00000000);
    rdc(8'hA0, 32'h00000000);
    rdc(8'hA2, 32'h00000000);
    bus16 = 1'b0;
    $display("test tally done");
    wr(8'hA8, 32'hCAFE0001);
    wr(8'hA4, 32'h80000012);
    poll();
    lag = 8'h14;
    wr(8'hA8, 32'h11112222);
    wr(8'hA4, 32'h80000034);
    wr(8'hA8, 32'h00000000);
    rdc(8'hA8, 32'h11112222);
    poll();
    wr(8'hA4, 32'hC0000034);
    poll();
    rdc(8'hA8, 32'h11112222);
    rdc(8'hA4, 32'h40000034);
    lag = 8'h00;
    wr(8'hA4, 32'hC0000012);
    poll();
    rdc(8'hA8, 32'hCAFE0001);
    $display("test mac access done");
    txWordIn = 32'hA1B2C3D4;
    txWordValid = 1'b1;
    @(negedge mclk);
    txWordValid = 1'b0;
    chk("tx low", {16'h0, txHalf_ff}, 32'h0000C3D4);
    chk("tx low valid", {31'h0, txHalfValid_ff}, 32'h1);
    @(negedge mclk);
    chk("tx high", {16'h0, txHalf_ff}, 32'h0000A1B2);
    chk("tx high valid", {31'h0, txHalfValid_ff}, 32'h1);
    rxHalfIn = 16'h1111;
    rxHalfValid = 1'b1;
    @(negedge mclk);
    rxHalfIn = 16'h2222;
    @(negedge mclk);
    rxHalfValid = 1'b0;
    rxHalfIn = 16'hDDDD;
    n = 0;
    while (rxWordValid_ff !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    chk("rx valid", {31'h0, rxWordValid_ff}, 32'h1);
    chk("rx word", rxWord_ff, 32'h22221111);
    $display("test halfword stream done");
    stop_test();
  end
endmodule : tb
